// ===== shared/tup_pkg.sv
// shared constants, register map and state codes of the tape unit panel control
package tup_pkg;
   localparam int unsigned APB_ADDR_W = 8;
   localparam logic [APB_ADDR_W-1:0] CFG_OFFSET = 8'h00;
   localparam logic [APB_ADDR_W-1:0] STATUS_OFFSET = 8'h04;
   localparam int unsigned CFG_WIDTH = 6;
   localparam int unsigned CFG_DOUBLE_LOAD_BIT = 0;
   localparam int unsigned CFG_AUTO_ONLINE_BIT = 1;
   localparam int unsigned CFG_PANEL_DIS_OPT_BIT = 2;
   localparam int unsigned CFG_ADDR_SWITCH_BIT = 3;
   localparam int unsigned CFG_DUAL_DENSITY_BIT = 4;
   localparam int unsigned CFG_TRACK_COMBO_BIT = 5;
   localparam logic [CFG_WIDTH-1:0] CFG_RESET = 6'h08;
   localparam int unsigned STATUS_WIDTH = 16;
   localparam int unsigned BUTTON_COUNT = 8;
   localparam int unsigned LEVEL_COUNT = 17;
   localparam logic [LEVEL_COUNT-1:0] LEVEL_SYNC_RESET = 17'h003FF;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_TENSION = 4'h1,
      ST_SEEK_BOT = 4'h2,
      ST_LOADED = 4'h3,
      ST_RWD_FAST = 4'h4,
      ST_RWD_PAST = 4'h5,
      ST_RWD_BACK = 4'h6,
      ST_UNWIND = 4'h7,
      ST_ARMING = 4'h8
   } tup_state_type;
endpackage

// ===== rtl/tup_sync_edge.sv
// two-stage synchroniser with rising-edge pulse for a vector of pin inputs
`timescale 1ns/1ps
module tup_sync_edge #(
   parameter int unsigned WIDTH = 8,
   parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] level_out,
   output logic [WIDTH-1:0] rise_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] prev_q;

   initial begin
      if (WIDTH < 1) begin
         $error("tup_sync_edge: WIDTH must be at least 1");
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= RESET_VALUE;
         sync_q <= RESET_VALUE;
         prev_q <= RESET_VALUE;
      end else begin
         meta_q <= pin_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_out = sync_q;
   assign rise_out = sync_q & ~prev_q;
endmodule

// ===== rtl/tup_unit_match.sv
// unit address selection and match against the formatter select lines
`timescale 1ns/1ps
module tup_unit_match (
   input wire logic [1:0] addr_switch,
   input wire logic switch_fitted,
   input wire logic [3:0] select_asserted,
   output logic [1:0] unit_addr,
   output logic match
);
   assign unit_addr = switch_fitted ? addr_switch : 2'h0;
   assign match = select_asserted[unit_addr];
endmodule

// ===== rtl/tup_panel_ctrl.sv
// front panel, load/rewind sequencing and formatter interface of the tape unit
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/1ps
module tup_panel_ctrl #(
   parameter int unsigned ADDR_W = tup_pkg::APB_ADDR_W
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LOAD_BUTTON,
   input wire logic ONLINE_BUTTON,
   input wire logic RESET_BUTTON,
   input wire logic REWIND_BUTTON,
   input wire logic HIGH_DENSITY_SWITCH,
   input wire logic TRACK_SWITCH,
   input wire logic MANUAL_FWD_SWITCH,
   input wire logic MANUAL_REV_SWITCH,
   input wire logic [1:0] ADDRESS_SWITCH,
   input wire logic TAPE_BEGIN_MARKER,
   input wire logic TAPE_END_MARKER,
   input wire logic ARMS_TENSIONED,
   input wire logic TAPE_CLEAR,
   input wire logic WRITE_PROTECT_SENSE,
   input wire logic [3:0] UNIT_SELECT_LINES_N,
   input wire logic REMOTE_OFFLINE_COMMAND_N,
   input wire logic DENSITY_SELECT_LINE_N,
   input wire logic FORWARD_COMMAND_N,
   input wire logic REVERSE_COMMAND_N,
   input wire logic REWIND_COMMAND_N,
   input wire logic WRITE_COMMAND_N,
   output logic TENSION_ENABLE,
   output logic MOTOR_FORWARD,
   output logic MOTOR_REVERSE,
   output logic MOTOR_HIGH_SPEED,
   output logic LOAD_LAMP,
   output logic ONLINE_LAMP,
   output logic RESET_LAMP,
   output logic DENSITY_LAMP,
   output logic TRACK9_LAMP,
   output logic WRITE_PROTECT_LAMP,
   output logic WRITE_ENABLE,
   output logic BEGIN_MARKER_STATUS_N,
   output logic END_MARKER_STATUS_N,
   output logic ONLINE_STATUS_N
);
   localparam int unsigned NB = tup_pkg::BUTTON_COUNT;
   localparam int unsigned NL = tup_pkg::LEVEL_COUNT;

   initial begin
      if (ADDR_W < 3) begin
         $error("tup_panel_ctrl: ADDR_W too small for the register map");
      end
   end

   logic [NB-1:0] btn_lvl;
   logic [NB-1:0] btn_rise;
   logic [NL-1:0] lvl_sync;
   logic load_p, online_p, reset_p, rwd_p, dens_p, track_p, mfwd_s, mrev_s;
   logic [1:0] addr_sw_s;
   logic bot_s, eot_s, arms_s, clear_s, wp_s;
   logic [3:0] sel_n_s;
   logic roff_n_s, dds_n_s, fwd_n_s, rev_n_s, rwd_n_s, wr_n_s;
   logic [3:0] sel_s;
   logic roff_s, dds_s, fwdc_s, revc_s, rwdc_s, wrc_s;
   logic [1:0] unit_addr;
   logic match;

   tup_sync_edge #(.WIDTH(NB)) u_btn_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .pin_in({MANUAL_REV_SWITCH, MANUAL_FWD_SWITCH, TRACK_SWITCH, HIGH_DENSITY_SWITCH,
               REWIND_BUTTON, RESET_BUTTON, ONLINE_BUTTON, LOAD_BUTTON}),
      .level_out(btn_lvl),
      .rise_out(btn_rise)
   );

   // active-low lines reset to their idle high level
   tup_sync_edge #(.WIDTH(NL), .RESET_VALUE(tup_pkg::LEVEL_SYNC_RESET)) u_lvl_sync (
      .clk(SYS_CLK),
      .rst(RST),
      .pin_in({ADDRESS_SWITCH, TAPE_BEGIN_MARKER, TAPE_END_MARKER, ARMS_TENSIONED,
               TAPE_CLEAR, WRITE_PROTECT_SENSE, UNIT_SELECT_LINES_N,
               REMOTE_OFFLINE_COMMAND_N, DENSITY_SELECT_LINE_N, FORWARD_COMMAND_N,
               REVERSE_COMMAND_N, REWIND_COMMAND_N, WRITE_COMMAND_N}),
      .level_out(lvl_sync),
      .rise_out()
   );

   assign {rwd_p, reset_p, online_p, load_p} = btn_rise[3:0];
   assign track_p = btn_rise[5];
   assign dens_p = btn_rise[4];
   assign {mrev_s, mfwd_s} = btn_lvl[7:6];
   assign {addr_sw_s, bot_s, eot_s, arms_s, clear_s, wp_s, sel_n_s} = lvl_sync[16:6];
   assign {roff_n_s, dds_n_s, fwd_n_s, rev_n_s, rwd_n_s, wr_n_s} = lvl_sync[5:0];

   assign sel_s = ~sel_n_s;
   assign {roff_s, dds_s, fwdc_s, revc_s, rwdc_s, wrc_s} =
      ~{roff_n_s, dds_n_s, fwd_n_s, rev_n_s, rwd_n_s, wr_n_s};

   logic [tup_pkg::CFG_WIDTH-1:0] cfg_q;
   logic cfg_double, cfg_auto, cfg_pdis, cfg_addr, cfg_dual, cfg_combo;
   assign cfg_double = cfg_q[tup_pkg::CFG_DOUBLE_LOAD_BIT];
   assign cfg_auto = cfg_q[tup_pkg::CFG_AUTO_ONLINE_BIT];
   assign cfg_pdis = cfg_q[tup_pkg::CFG_PANEL_DIS_OPT_BIT];
   assign cfg_addr = cfg_q[tup_pkg::CFG_ADDR_SWITCH_BIT];
   assign cfg_dual = cfg_q[tup_pkg::CFG_DUAL_DENSITY_BIT];
   assign cfg_combo = cfg_q[tup_pkg::CFG_TRACK_COMBO_BIT];

   tup_unit_match u_match (
      .addr_switch(addr_sw_s),
      .switch_fitted(cfg_addr),
      .select_asserted(sel_s),
      .unit_addr(unit_addr),
      .match(match)
   );

   tup_pkg::tup_state_type state_q, state_d;
   logic online_q, online_n_q, selected_q, panel_dis_q, load_lamp_q, density_q, track9_q;
   logic fwd_q, rev_q, fast_q, tension_q, fwd_d, rev_d, fast_d, tension_d;
   logic panel_ok, accept;

   assign panel_ok = ~panel_dis_q;
   // remote commands need on line and address match
   assign accept = online_q & selected_q;

   always_comb begin
      state_d = state_q;
      fwd_d = 1'b0;
      rev_d = 1'b0;
      fast_d = 1'b0;
      tension_d = 1'b1;
      case (state_q)
         tup_pkg::ST_IDLE: begin
            tension_d = 1'b0;
            if (load_p && panel_ok) begin
               state_d = tup_pkg::ST_ARMING;
            end
         end
         tup_pkg::ST_ARMING: begin
            if (arms_s) begin
               state_d = cfg_double ? tup_pkg::ST_TENSION : tup_pkg::ST_SEEK_BOT;
            end
         end
         tup_pkg::ST_TENSION: begin
            if (load_p && panel_ok) begin
               state_d = tup_pkg::ST_SEEK_BOT;
            end
         end
         tup_pkg::ST_SEEK_BOT: begin
            if (bot_s) begin
               state_d = tup_pkg::ST_LOADED;
            end else begin
               fwd_d = 1'b1;
            end
         end
         tup_pkg::ST_LOADED: begin
            if (accept) begin
               if (rwdc_s && !bot_s) begin
                  state_d = tup_pkg::ST_RWD_FAST;
               end else if (fwdc_s && !eot_s) begin
                  fwd_d = 1'b1;
               end else if (revc_s && !bot_s) begin
                  rev_d = 1'b1;
               end
            end else if (!online_q && panel_ok) begin
               // forward of marker rewind returns to it
               if (rwd_p) begin
                  state_d = bot_s ? tup_pkg::ST_UNWIND : tup_pkg::ST_RWD_FAST;
               end else if (mfwd_s) begin
                  fwd_d = 1'b1;
               end else if (mrev_s && !bot_s) begin
                  rev_d = 1'b1;
               end
            end
         end
         tup_pkg::ST_RWD_FAST: begin
            rev_d = 1'b1;
            fast_d = 1'b1;
            if (bot_s) begin
               state_d = tup_pkg::ST_RWD_PAST;
            end
         end
         tup_pkg::ST_RWD_PAST: begin
            rev_d = 1'b1;
            if (!bot_s) begin
               state_d = tup_pkg::ST_RWD_BACK;
            end
         end
         tup_pkg::ST_RWD_BACK: begin
            if (bot_s) begin
               state_d = tup_pkg::ST_LOADED;
            end else begin
               fwd_d = 1'b1;
            end
         end
         tup_pkg::ST_UNWIND: begin
            if (clear_s) begin
               tension_d = 1'b0;
               state_d = tup_pkg::ST_IDLE;
            end else begin
               rev_d = 1'b1;
            end
         end
         default: begin
            state_d = tup_pkg::ST_IDLE;
         end
      endcase
   end

   // all motion and lamps off at reset
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_q <= tup_pkg::ST_IDLE;
         fwd_q <= 1'b0;
         rev_q <= 1'b0;
         fast_q <= 1'b0;
         tension_q <= 1'b0;
      end else begin
         state_q <= state_d;
         fwd_q <= fwd_d;
         rev_q <= rev_d;
         fast_q <= fast_d;
         tension_q <= tension_d;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         online_q <= 1'b0;
         online_n_q <= 1'b1;
      // reset or on-line press goes off line
      // remote offline and reset never set on line
      end else if (online_q && (reset_p || online_p || (selected_q && roff_s))) begin
         online_q <= 1'b0;
         online_n_q <= 1'b1;
      end else if (cfg_auto && state_q == tup_pkg::ST_SEEK_BOT && bot_s) begin
         online_q <= 1'b1;
         online_n_q <= 1'b0;
      end else if (!online_q && online_p && panel_ok && state_q == tup_pkg::ST_LOADED) begin
         online_q <= 1'b1;
         online_n_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST || !cfg_pdis) begin
         panel_dis_q <= 1'b0;
      end else if (reset_p) begin
         panel_dis_q <= ~panel_dis_q;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         selected_q <= 1'b0;
      end else begin
         selected_q <= match;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST || state_q == tup_pkg::ST_IDLE) begin
         load_lamp_q <= 1'b0;
      // load ends at marker with lamp
      end else if (state_q == tup_pkg::ST_SEEK_BOT && bot_s) begin
         load_lamp_q <= 1'b1;
      end else if (fwd_q && !bot_s) begin
         load_lamp_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         density_q <= 1'b0;
      end else if (dens_p && cfg_dual && panel_ok) begin
         density_q <= ~density_q;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         track9_q <= 1'b0;
      end else if (track_p && cfg_combo && panel_ok) begin
         track9_q <= ~track9_q;
      end
   end

   logic dens_lamp_q, wp_lamp_q, wr_en_q, bot_n_q, eot_n_q;
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         dens_lamp_q <= 1'b0;
         wp_lamp_q <= 1'b0;
         wr_en_q <= 1'b0;
         bot_n_q <= 1'b1;
         eot_n_q <= 1'b1;
      end else begin
         dens_lamp_q <= density_q | (accept & dds_s);
         wp_lamp_q <= wp_s & tension_q;
         wr_en_q <= accept & wrc_s & (state_q == tup_pkg::ST_LOADED);
         // status lines driven low when true
         bot_n_q <= ~(bot_s & tension_q);
         eot_n_q <= ~(eot_s & tension_q);
      end
   end

   assign TENSION_ENABLE = tension_q;
   assign MOTOR_FORWARD = fwd_q;
   assign MOTOR_REVERSE = rev_q;
   assign MOTOR_HIGH_SPEED = fast_q;
   assign LOAD_LAMP = load_lamp_q;
   assign ONLINE_LAMP = online_q;
   assign RESET_LAMP = selected_q;
   assign DENSITY_LAMP = dens_lamp_q;
   assign TRACK9_LAMP = track9_q;
   assign WRITE_PROTECT_LAMP = wp_lamp_q;
   assign WRITE_ENABLE = wr_en_q;
   assign BEGIN_MARKER_STATUS_N = bot_n_q;
   assign END_MARKER_STATUS_N = eot_n_q;
   assign ONLINE_STATUS_N = online_n_q;

   // apb slave: answer in the first access cycle
   logic [31:0] rdata_q;
   logic ready_q, slverr_q, setup, hit_cfg, hit_stat;
   logic [tup_pkg::STATUS_WIDTH-1:0] status;
   assign setup = PSEL & ~PENABLE;
   assign hit_cfg = PADDR == tup_pkg::CFG_OFFSET;
   assign hit_stat = PADDR == tup_pkg::STATUS_OFFSET;
   assign status = {2'h0, unit_addr, bot_s, panel_dis_q, track9_q, density_q,
                    load_lamp_q, selected_q, online_q, tension_q, state_q};

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ready_q <= 1'b0;
         slverr_q <= 1'b0;
         rdata_q <= 32'h0;
      end else begin
         ready_q <= setup;
         slverr_q <= setup & ~(hit_cfg | (hit_stat & ~PWRITE));
         if (setup) begin
            if (PWRITE) begin
               rdata_q <= 32'h0;
            end else if (hit_cfg) begin
               rdata_q <= {{(32 - tup_pkg::CFG_WIDTH){1'b0}}, cfg_q};
            end else if (hit_stat) begin
               rdata_q <= {{(32 - tup_pkg::STATUS_WIDTH){1'b0}}, status};
            end else begin
               rdata_q <= 32'h0;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg_q <= tup_pkg::CFG_RESET;
      end else if (PSEL && PENABLE && ready_q && PWRITE && hit_cfg) begin
         cfg_q <= PWDATA[tup_pkg::CFG_WIDTH-1:0];
      end
   end

   assign PREADY = ready_q;
   assign PSLVERR = slverr_q;
   assign PRDATA = rdata_q;

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);

   sequence s_past_done;
      state_q == tup_pkg::ST_RWD_PAST && !bot_s;
   endsequence
   sequence s_return;
      state_q == tup_pkg::ST_RWD_BACK;
   endsequence
   sequence s_unwind_req;
      state_q == tup_pkg::ST_LOADED && !accept && !online_q && panel_ok && rwd_p && bot_s;
   endsequence

   a_density_toggle: assert property (dens_p && cfg_dual && panel_ok |=> density_q != $past(density_q))
      else $error("density selection did not toggle");
   a_track_toggle: assert property (track_p && cfg_combo && panel_ok |=> TRACK9_LAMP != $past(TRACK9_LAMP))
      else $error("track lamp did not toggle");
   a_select_match: assert property (##1 RESET_LAMP == $past(sel_s[unit_addr]))
      else $error("reset lamp does not follow select match");
   a_addr_zero: assert property (!cfg_addr |-> unit_addr == 2'h0)
      else $error("unit address not zero without switch");
   a_double_stop: assert property (state_q == tup_pkg::ST_ARMING && arms_s && cfg_double |=> state_q == tup_pkg::ST_TENSION ##1 !MOTOR_FORWARD)
      else $error("double load did not stop after tensioning");
   a_bot_lamp: assert property (state_q == tup_pkg::ST_SEEK_BOT && bot_s |=> LOAD_LAMP && state_q == tup_pkg::ST_LOADED)
      else $error("load lamp not lit at marker");
   a_lamp_off: assert property (LOAD_LAMP && MOTOR_FORWARD && !bot_s |=> !LOAD_LAMP)
      else $error("load lamp stayed lit off marker");
   a_auto_online: assert property (cfg_auto && state_q == tup_pkg::ST_SEEK_BOT && bot_s && !online_q |=> ONLINE_LAMP)
      else $error("auto on line missed");
   a_force_off: assert property (online_q && (reset_p || (selected_q && roff_s)) |=> !ONLINE_LAMP && ONLINE_STATUS_N)
      else $error("offline request ignored");
   a_unwind_run: assert property (s_unwind_req |=> state_q == tup_pkg::ST_UNWIND ##1 (MOTOR_REVERSE || clear_s) && !MOTOR_HIGH_SPEED)
      else $error("unwind did not start slow reverse");
   a_rewind_back: assert property (s_past_done |=> s_return)
      else $error("rewind did not turn back at marker");
   a_ignore_remote: assert property (!accept && state_q == tup_pkg::ST_LOADED |=> !WRITE_ENABLE)
      else $error("remote write accepted while not addressed");
endmodule

// ===== tb/tup_formatter_model.sv
// behavioural tape formatter driving the negative-true select and command lines
`timescale 1ns/1ps
module tup_formatter_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic online_n,
   input wire logic sel_req,
   input wire logic [1:0] sel_addr,
   input wire logic fwd_req,
   input wire logic off_req,
   input wire logic wr_req,
   input wire logic dens_req,
   output logic [3:0] sel_n,
   output logic off_n,
   output logic dens_n,
   output logic fwd_n,
   output logic rev_n,
   output logic rwd_n,
   output logic wr_n
);
   logic take_q;
   // control only once the unit is on line
   always_ff @(posedge clk) begin
      if (rst) begin
         take_q <= 1'b0;
      end else begin
         take_q <= sel_req & ~online_n;
      end
   end
   // low asserts, one select line per address
   always_ff @(posedge clk) begin
      if (rst) begin
         sel_n <= 4'hF;
         off_n <= 1'b1;
         fwd_n <= 1'b1;
         wr_n <= 1'b1;
         dens_n <= 1'b1;
      end else begin
         sel_n <= take_q ? ~(4'h1 << sel_addr) : 4'hF;
         off_n <= ~(take_q & off_req);
         fwd_n <= ~(take_q & fwd_req);
         wr_n <= ~(take_q & wr_req);
         dens_n <= ~(take_q & dens_req);
      end
   end
   assign rev_n = 1'b1;
   assign rwd_n = 1'b1;
endmodule

// ===== tb/tb_tup_panel_ctrl.sv
// self-checking bench for the tape unit panel control
`timescale 1ns/1ps
module tb_tup_panel_ctrl;
   logic clk, rst, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [5:0] btn;
   logic fwd_sw, rev_sw, tape_begin_marker, tape_end_marker, arms, clr, wp;
   logic [1:0] asw, sel_addr;
   logic sel_req, fwd_req, off_req, wr_req, dens_req, online_n, err;
   logic [3:0] sel_n;
   logic off_n, dens_n, fwd_n, rev_n, rwd_n, wr_n;
   logic ten, mf, mr, mhs, load_l, onl_l, rst_l, den_l, t9_l, wp_l, wen, bot_n, eot_n;
   int fail_count, comparisons, cyc;
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   tup_formatter_model fmt (.clk(clk), .rst(rst), .online_n(online_n), .sel_req(sel_req),
      .wr_req(wr_req), .dens_req(dens_req),
      .sel_addr(sel_addr), .fwd_req(fwd_req), .off_req(off_req), .sel_n(sel_n), .off_n(off_n),
      .dens_n(dens_n), .fwd_n(fwd_n), .rev_n(rev_n), .rwd_n(rwd_n), .wr_n(wr_n));
   tup_panel_ctrl dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .LOAD_BUTTON(btn[0]), .ONLINE_BUTTON(btn[1]), .RESET_BUTTON(btn[2]),
      .REWIND_BUTTON(btn[3]), .HIGH_DENSITY_SWITCH(btn[4]), .TRACK_SWITCH(btn[5]),
      .MANUAL_FWD_SWITCH(fwd_sw), .MANUAL_REV_SWITCH(rev_sw), .ADDRESS_SWITCH(asw),
      .TAPE_BEGIN_MARKER(tape_begin_marker), .TAPE_END_MARKER(tape_end_marker), .ARMS_TENSIONED(arms), .TAPE_CLEAR(clr),
      .WRITE_PROTECT_SENSE(wp), .UNIT_SELECT_LINES_N(sel_n), .REMOTE_OFFLINE_COMMAND_N(off_n),
      .DENSITY_SELECT_LINE_N(dens_n), .FORWARD_COMMAND_N(fwd_n), .REVERSE_COMMAND_N(rev_n),
      .REWIND_COMMAND_N(rwd_n), .WRITE_COMMAND_N(wr_n), .TENSION_ENABLE(ten),
      .MOTOR_FORWARD(mf), .MOTOR_REVERSE(mr), .MOTOR_HIGH_SPEED(mhs), .LOAD_LAMP(load_l),
      .ONLINE_LAMP(onl_l), .RESET_LAMP(rst_l), .DENSITY_LAMP(den_l), .TRACK9_LAMP(t9_l),
      .WRITE_PROTECT_LAMP(wp_l), .WRITE_ENABLE(wen), .BEGIN_MARKER_STATUS_N(bot_n),
      .END_MARKER_STATUS_N(eot_n), .ONLINE_STATUS_N(online_n));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic press(input int i);
      btn[i] <= 1'b1;
      step(4);
      btn[i] <= 1'b0;
      step(6);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, btn} = '0;
      {fwd_sw, rev_sw, tape_begin_marker, tape_end_marker, arms, clr, wp, sel_req, fwd_req, off_req, wr_req, dens_req} = '0;
      asw = 2'h2;
      sel_addr = 2'h0;
      fail_count = 0;
      comparisons = 0;
      cyc = 0;
      rst = 1'b1;
      step(3);
      rst <= 1'b0;
      step(2);
      chk("lamps", {load_l, onl_l, rst_l, den_l, t9_l, ten, mf, mr}, 32'h0);
      chk("status_n", {bot_n, eot_n, online_n}, 32'h7);
      apb(1'b0, tup_pkg::CFG_OFFSET, 32'h0);
      chk("cfg", rd, 32'h8);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped", {31'h0, err}, 32'h1);
      $display("test reset done");
      apb(1'b1, tup_pkg::CFG_OFFSET, 32'h38);
      press(4);
      chk("density on", {31'h0, den_l}, 32'h1);
      press(4);
      chk("density off", {31'h0, den_l}, 32'h0);
      press(5);
      chk("track9", {31'h0, t9_l}, 32'h1);
      $display("test switches done");
      press(0);
      chk("tension", {ten, mf}, 32'h2);
      arms <= 1'b1;
      step(5);
      chk("seek", {31'h0, mf}, 32'h1);
      tape_begin_marker <= 1'b1;
      step(5);
      chk("loaded", {mf, load_l, onl_l}, 32'h2);
      press(1);
      chk("online", {onl_l, online_n}, 32'h2);
      sel_req <= 1'b1;
      sel_addr <= 2'h1;
      fwd_req <= 1'b1;
      {wr_req, dens_req} <= 2'h3;
      step(6);
      chk("not sel", {rst_l, mf}, 32'h0);
      chk("not sel write", {wen, den_l}, 32'h0);
      sel_addr <= 2'h2;
      step(6);
      chk("selected fwd", {rst_l, mf}, 32'h3);
      chk("selected write", {31'h0, wen}, 32'h1);
      chk("remote density", {31'h0, den_l}, 32'h1);
      tape_begin_marker <= 1'b0;
      step(5);
      chk("lamp off", {31'h0, load_l}, 32'h0);
      off_req <= 1'b1;
      step(6);
      chk("remote off", {onl_l, online_n}, 32'h1);
      chk("write off", {wen, den_l}, 32'h0);
      {fwd_req, off_req, wr_req, dens_req} <= 4'h0;
      step(4);
      $display("test load done");
      press(3);
      chk("rwd fast", {mf, mr, mhs}, 32'h3);
      tape_begin_marker <= 1'b1;
      step(5);
      chk("rwd past", {mf, mr, mhs}, 32'h2);
      tape_begin_marker <= 1'b0;
      step(5);
      chk("rwd back", {mf, mr}, 32'h2);
      tape_begin_marker <= 1'b1;
      step(5);
      chk("rwd stop", {mf, mr}, 32'h0);
      press(3);
      chk("unwind", {mf, mr, mhs}, 32'h2);
      clr <= 1'b1;
      arms <= 1'b0;
      step(5);
      chk("unwound", {ten, mr}, 32'h0);
      $display("test rewind done");
      apb(1'b1, tup_pkg::CFG_OFFSET, 32'h03);
      {clr, tape_begin_marker} <= 2'h0;
      asw <= 2'h3;
      press(0);
      arms <= 1'b1;
      step(5);
      chk("double first", {ten, mf}, 32'h2);
      press(0);
      chk("double second", {31'h0, mf}, 32'h1);
      tape_begin_marker <= 1'b1;
      step(5);
      chk("auto online", {mf, load_l, onl_l}, 32'h3);
      sel_addr <= 2'h0;
      step(6);
      chk("addr zero", {31'h0, rst_l}, 32'h1);
      press(2);
      chk("reset off", {31'h0, onl_l}, 32'h0);
      press(1);
      press(1);
      chk("online off", {31'h0, onl_l}, 32'h0);
      apb(1'b1, tup_pkg::CFG_OFFSET, 32'h07);
      press(2);
      press(3);
      chk("panel locked", {mf, mr}, 32'h0);
      apb(1'b0, tup_pkg::STATUS_OFFSET, 32'h0);
      chk("status locked", {31'h0, rd[10]}, 32'h1);
      wp <= 1'b1;
      step(5);
      chk("protect lamp", {31'h0, wp_l}, 32'h1);
      $display("test double load done");
      end_of_test();
   end
endmodule
